// ===== stm_params.svh
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH

// register indices on the plain register port
`define STM_ADDR_CTL0    3'h0
`define STM_ADDR_CTL1    3'h1
`define STM_ADDR_CNT_LO  3'h2
`define STM_ADDR_CNT_HI  3'h3
`define STM_ADDR_CMPA_LO 3'h4
`define STM_ADDR_CMPA_HI 3'h5

// reset values
`define STM_CTL0_RST 8'h00
`define STM_CTL1_RST 8'h00

// field positions of the control registers
`define STM_C0_PAUSE   7
`define STM_C0_ENABLE  3
`define STM_C1_CLRSEL  0

// prescaler terminal counts
`define STM_SYS_DIV_LAST  2'h3
`define STM_HI16_LAST     4'hf
`define STM_HI64_LAST     6'h3f

// counter geometry
`define STM_CNT_FULL   11'h400
`define STM_PSTEP_LSB  7

`endif

// ===== stm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module stm_pin_model (
  // controls from the bench
  input  wire logic extRun,
  input  wire logic capLevel,
  // pins toward the timer
  output logic      extClockPin,
  output logic      captureInPin
);
  initial extClockPin = 1'b0;

  // the external clock stands low between bursts; 80 ns period, phase unrelated to core_clk
  always begin
    wait (extRun);
    #43 extClockPin = 1'b1;
    #37 extClockPin = 1'b0;
  end

  // board delay, so the edge never lands on a core_clk edge
  assign #3 captureInPin = capLevel;
endmodule

`default_nettype wire

// ===== stm_pkg.sv
package stm_pkg;

  typedef enum logic [1:0] {
    STM_MODE_CMP = 2'h0,
    STM_MODE_CAP = 2'h1,
    STM_MODE_PWM = 2'h2,
    STM_MODE_TMR = 2'h3
  } stm_mode_t;

  typedef struct packed {
    logic       pauseCtl;
    logic [2:0] clockSelect;
    logic       moduleEnable;
    logic [2:0] periodCompareValue;
  } stm_ctl0_t;

  typedef struct packed {
    logic [1:0] modeSelect;
    logic [1:0] pinFunctionSelect;
    logic       outputInitialLevel;
    logic       outputInvert;
    logic       periodDutySwap;
    logic       clearSourceSelect;
  } stm_ctl1_t;

endpackage

// ===== stm_testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "stm_params.svh"

`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module testbench;
  import stm_pkg::*;

  logic       core_clk = 1'b0, arst_n = 1'b0, clkEn = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic       highClkTick = 1'b0, timebaseTick = 1'b0, extRun = 1'b0, capLevel = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00;
  logic [1:0] tickDiv = 2'h0;
  logic [7:0] regRdData;
  logic       extClockPin, captureInPin, timerOutPin, compareAFlag, comparePFlag;
  int         failures = 0, compares = 0, cyc = 0, aSeen = 0, pSeen = 0;

  stm_timer dut (
    .core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .highClkTick(highClkTick), .timebaseTick(timebaseTick),
    .extClockPin(extClockPin), .captureInPin(captureInPin), .timerOutPin(timerOutPin),
    .compareAFlag(compareAFlag), .comparePFlag(comparePFlag)
  );

  stm_pin_model pm (
    .extRun(extRun), .capLevel(capLevel), .extClockPin(extClockPin), .captureInPin(captureInPin)
  );

  always #5 core_clk = ~core_clk;

  // high clock ticks every 2nd cycle, timebase every 4th
  always @(posedge core_clk) begin
    tickDiv <= tickDiv + 2'h1;
    highClkTick <= tickDiv[0];
    timebaseTick <= &tickDiv;
  end

  // sampled on the falling edge so registered flags are settled
  always @(negedge core_clk) begin
    cyc++;
    aSeen += int'(compareAFlag === 1'b1);
    pSeen += int'(comparePFlag === 1'b1);
    if (cyc == 90000) begin
      failures++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic rd_cnt(output logic [9:0] c);
    logic [7:0] h, l;
    rd(`STM_ADDR_CNT_HI, h);
    rd(`STM_ADDR_CNT_LO, l);
    c = {h[1:0], l};
  endtask

  // off before mode or function change
  task automatic setup(input logic [7:0] c1, input logic [7:0] c0);
    wr(`STM_ADDR_CTL0, c0 & 8'hf7);
    wr(`STM_ADDR_CTL1, c1);
    wr(`STM_ADDR_CTL0, c0);
  endtask

  task automatic wr_cmpa(input logic [9:0] v);
    wr(`STM_ADDR_CMPA_LO, v[7:0]);
    wr(`STM_ADDR_CMPA_HI, {6'h00, v[9:8]});
  endtask

  // cycles up to the next flag, and how many of them had the pin high
  task automatic wait_flag(input logic isA, output int n, output int hi);
    n = 0;
    hi = 0;
    do begin
      @(negedge core_clk);
      n++;
      hi += int'(timerOutPin === 1'b1);
    end while ((isA ? compareAFlag : comparePFlag) !== 1'b1 && n < 20000);
  endtask

  task automatic span(input logic isA, output int n, output int hi);
    wait_flag(isA, n, hi);
    wait_flag(isA, n, hi);
  endtask

  task automatic t_regs;
    logic [7:0] d;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), d);
      `CHK(d, 8'h00)
    end
    wr(`STM_ADDR_CTL1, 8'h5a);
    rd(`STM_ADDR_CTL1, d);
    `CHK(d, 8'h5a)
    wr(`STM_ADDR_CTL1, 8'h00);
    wr(`STM_ADDR_CNT_LO, 8'h33);
    wr(3'h6, 8'h44);
    rd(`STM_ADDR_CNT_LO, d);
    `CHK(d, 8'h00)
    rd(3'h6, d);
    `CHK(d, 8'h00)
  endtask

  task automatic t_pair;
    logic [7:0] d;
    wr(`STM_ADDR_CMPA_LO, 8'h5a);
    @(posedge core_clk);
    clkEn <= 1'b0;
    wr(`STM_ADDR_CMPA_HI, 8'h03);
    clkEn <= 1'b1;
    rd(`STM_ADDR_CMPA_HI, d);
    `CHK(d, 8'h00)
    rd(`STM_ADDR_CMPA_LO, d);
    `CHK(d, 8'h00)
    wr(`STM_ADDR_CMPA_LO, 8'h5a);
    wr(`STM_ADDR_CMPA_HI, 8'hfe);
    rd(`STM_ADDR_CMPA_HI, d);
    `CHK(d, 8'h02)
    rd(`STM_ADDR_CMPA_LO, d);
    `CHK(d, 8'h5a)
  endtask

  task automatic t_clock;
    int n, hi;
    logic [2:0] s;
    int rate [8] = '{512, 128, 4096, 16384, 512, 512, 1024, 1024};
    wr_cmpa(10'h000);
    for (int i = 0; i < 8; i++) begin
      s = 3'(i);
      extRun <= s[2] & s[1];
      setup(8'h00, {1'b0, s, 1'b1, 3'h1});
      span(1'b0, n, hi);
      `CHK(n, rate[i])
    end
    extRun <= 1'b0;
    for (int p = 0; p < 8; p++) begin
      setup(8'h00, {5'b00011, 3'(p)});
      span(1'b0, n, hi);
      `CHK(n, (p == 0) ? 1024 : p * 128)
    end
  endtask

  task automatic t_clear;
    int n, hi, p0;
    wr_cmpa(10'h100);
    setup(8'h01, 8'h19);
    p0 = pSeen;
    span(1'b1, n, hi);
    `CHK(n, 256)
    `CHK(pSeen - p0, 0)
    wr_cmpa(10'h040);
    setup(8'h00, 8'h19);
    span(1'b1, n, hi);
    `CHK(n, 128)
    span(1'b0, n, hi);
    `CHK(n, 128)
  endtask

  task automatic t_hold;
    logic [9:0] a, b, c;
    setup(8'h00, 8'h18);
    repeat (20) @(posedge core_clk);
    wr(`STM_ADDR_CTL0, 8'h98);
    rd_cnt(a);
    repeat (40) @(posedge core_clk);
    rd_cnt(b);
    `CHK(b, a)
    wr(`STM_ADDR_CTL0, 8'h18);
    repeat (40) @(posedge core_clk);
    rd_cnt(c);
    `CHK((c - b) inside {[10'd40:10'd60]}, 1'b1)
    wr(`STM_ADDR_CTL0, 8'h10);
    rd_cnt(a);
    repeat (40) @(posedge core_clk);
    rd_cnt(b);
    `CHK(b, a)
    wr(`STM_ADDR_CTL0, 8'h18);
    rd_cnt(c);
    `CHK(c < 10'd8, 1'b1)
  endtask

  // function, initial level, invert; pin after enable, after 1st and 2nd A match
  task automatic t_compare;
    int n, hi;
    logic [6:0] tbl [5] = '{7'b1000011, 7'b0110100, 7'b0010111, 7'b1101101, 7'b0100000};
    wr_cmpa(10'h020);
    foreach (tbl[i]) begin
      setup({2'b00, tbl[i][6:3], 2'b01}, 8'h18);
      repeat (4) @(negedge core_clk);
      `CHK(timerOutPin, tbl[i][2])
      wait_flag(1'b1, n, hi);
      repeat (2) @(negedge core_clk);
      `CHK(timerOutPin, tbl[i][1])
      wait_flag(1'b1, n, hi);
      repeat (2) @(negedge core_clk);
      `CHK(timerOutPin, tbl[i][0])
    end
    // timer mode with invert set must leave the pin where it was
    setup(8'hc4, 8'h18);
    repeat (4) @(negedge core_clk);
    `CHK(timerOutPin, 1'b0)
  endtask

  // function, level, invert, swap, then high cycles per period; clear source set to be ignored
  task automatic t_pwm;
    int n, hi;
    logic [12:0] tbl [7] = '{{5'b10100, 8'd32}, {5'b10000, 8'd96}, {5'b10110, 8'd96},
                             {5'b00100, 8'd0}, {5'b01100, 8'd128}, {5'b10101, 8'd32},
                             {5'b11100, 8'd0}};
    wr_cmpa(10'h020);
    foreach (tbl[i]) begin
      setup({2'b10, tbl[i][12:8], 1'b1}, 8'h19);
      span(tbl[i][8], n, hi);
      `CHK(n, tbl[i][8] ? 32 : 128)
      `CHK(hi, int'(tbl[i][7:0]))
    end
  endtask

  // counter held at zero by pause, so no compare match can mix with capture events
  task automatic t_capture;
    int a0;
    logic [1:0] tbl [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
    foreach (tbl[i]) begin
      setup({2'b01, 2'(i), 4'h0}, 8'h88);
      a0 = aSeen;
      capLevel <= 1'b1;
      repeat (12) @(posedge core_clk);
      `CHK(aSeen - a0, int'(tbl[i][1]))
      a0 = aSeen;
      capLevel <= 1'b0;
      repeat (12) @(posedge core_clk);
      `CHK(aSeen - a0, int'(tbl[i][0]))
    end
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs();
    t_pair();
    t_clock();
    t_clear();
    t_hold();
    t_compare();
    t_pwm();
    t_capture();
    finish_test();
  end
endmodule

`default_nettype wire

// ===== stm_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "stm_params.svh"

module stm_tick_gen
  import stm_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       clkEn,
  // source selection
  input  wire logic [2:0] clockSelect,
  input  wire logic       highClkTick,
  input  wire logic       timebaseTick,
  input  wire logic       extClockPin,
  // counter advance
  output logic            countTick
);

  logic [1:0] sysDiv_ff;
  logic [5:0] hiDiv_ff;
  logic [2:0] extSync_ff;
  logic       extRise;
  logic       extFall;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sysDiv_ff <= 2'h0;
    end else if (clkEn) begin
      sysDiv_ff <= sysDiv_ff + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hiDiv_ff <= 6'h00;
    end else if (clkEn && highClkTick) begin
      hiDiv_ff <= hiDiv_ff + 6'h01;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      extSync_ff <= 3'h0;
    end else if (clkEn) begin
      extSync_ff <= {extSync_ff[1:0], extClockPin};
    end
  end

  // stage 0 is only ever read by stage 1
  assign extRise = extSync_ff[1] & ~extSync_ff[2];
  assign extFall = ~extSync_ff[1] & extSync_ff[2];

  always_comb begin
    case (clockSelect)
      3'h0:    countTick = (sysDiv_ff == `STM_SYS_DIV_LAST);
      3'h1:    countTick = 1'b1;
      3'h2:    countTick = highClkTick && (hiDiv_ff[3:0] == `STM_HI16_LAST);
      3'h3:    countTick = highClkTick && (hiDiv_ff == `STM_HI64_LAST);
      3'h4:    countTick = timebaseTick;
      3'h5:    countTick = timebaseTick;
      3'h6:    countTick = extRise;
      default: countTick = extFall;
    endcase
  end

endmodule

`default_nettype wire

// ===== stm_timer.sv
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "stm_params.svh"

// Operation
// - pause bit stops counting, clearing resumes
// - pause holds count, resumes from held value
// - clock select picks one of seven sources
// - enable rise zeroes counter; runs while enabled
// - enable fall freezes counter until re-enabled
// - enable rise forces pin to initial level, inverse for PWM inactive; capture and timer leave it
// - period value matches counter bits nine..seven
// - zero period lets counter overflow naturally
// - mode field selects compare, capture, PWM, timer
// - compare mode pin action on A match
// - PWM mode function: inactive, active, PWM, pulse
// - capture mode edge select: rise, fall, both, off
// - requested level equal to pin: no change
// - initial level bit sets level or polarity
// - invert bit flips pin except timer mode
// - swap bit exchanges period and duty roles
// - clear source: A match, else P/overflow
// - clear source ignored in PWM and capture
// - timer mode leaves pin undefined, function unused
// - counter readable, compare A read/write pairs
// - low bytes pass through buffer, high commits
// - P flag only when clear source low in compare and timer modes; PWM and capture always raise it
module stm_timer
  import stm_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       clkEn,
  // register port
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  // internal clock ticks
  input  wire logic       highClkTick,
  input  wire logic       timebaseTick,
  // pins
  input  wire logic       extClockPin,
  input  wire logic       captureInPin,
  output logic            timerOutPin,
  // compare events
  output logic            compareAFlag,
  output logic            comparePFlag
);

  stm_ctl0_t   ctl0_ff;
  stm_ctl1_t   ctl1_ff;
  stm_mode_t   mode;
  logic [9:0]  count_ff;
  logic [9:0]  cmpA_ff;
  logic [7:0]  cntBuf_ff;
  logic [7:0]  cmpBuf_ff;
  logic        enPrev_ff;
  logic        pinLevel_ff;
  logic [2:0]  capSync_ff;
  logic        tick;
  logic        enRise;
  logic        running;
  logic [10:0] nxtCount;
  logic [10:0] pLen;
  logic [10:0] aLen;
  logic [10:0] pwmPeriod;
  logic [10:0] pwmDuty;
  logic        ovfHit;
  logic        pHit;
  logic        aHit;
  logic        clearHit;
  logic        capEvent;
  logic        nxt_aFlag;
  logic        nxt_pFlag;
  logic        cmpLike;

  stm_tick_gen u_tick (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .clkEn        (clkEn),
    .clockSelect  (ctl0_ff.clockSelect),
    .highClkTick  (highClkTick),
    .timebaseTick (timebaseTick),
    .extClockPin  (extClockPin),
    .countTick    (tick)
  );

  assign mode    = stm_mode_t'(ctl1_ff.modeSelect);
  assign cmpLike = (mode == STM_MODE_CMP) || (mode == STM_MODE_TMR);
  assign enRise  = ctl0_ff.moduleEnable & ~enPrev_ff;
  assign running = ctl0_ff.moduleEnable & ~ctl0_ff.pauseCtl & tick;

  assign nxtCount = {1'b0, count_ff} + 11'h001;
  assign ovfHit   = (nxtCount == `STM_CNT_FULL);
  // period in 128-count steps, zero means full range
  assign pLen = (ctl0_ff.periodCompareValue == 3'h0) ? `STM_CNT_FULL :
                {1'b0, ctl0_ff.periodCompareValue, 7'h00};
  assign aLen = (cmpA_ff == 10'h000) ? `STM_CNT_FULL : {1'b0, cmpA_ff};
  assign pHit = (nxtCount == pLen);
  // a zero compare A value never raises the A flag
  assign aHit = (cmpA_ff != 10'h000) && (nxtCount == {1'b0, cmpA_ff});

  assign pwmPeriod = ctl1_ff.periodDutySwap ? aLen : pLen;
  assign pwmDuty   = ctl1_ff.periodDutySwap ? pLen : {1'b0, cmpA_ff};

  always_comb begin
    case (mode)
      STM_MODE_PWM: clearHit = (nxtCount == pwmPeriod);
      STM_MODE_CAP: clearHit = pHit;
      default:      clearHit = ctl1_ff.clearSourceSelect ? (aHit | ovfHit) : pHit;
    endcase
  end

  always_comb begin
    case (ctl1_ff.pinFunctionSelect)
      2'h0:    capEvent = capSync_ff[1] & ~capSync_ff[2];
      2'h1:    capEvent = ~capSync_ff[1] & capSync_ff[2];
      2'h2:    capEvent = capSync_ff[1] ^ capSync_ff[2];
      default: capEvent = 1'b0;
    endcase
    capEvent = capEvent & (mode == STM_MODE_CAP) & ctl0_ff.moduleEnable;
  end

  assign nxt_aFlag = (running & aHit & (mode != STM_MODE_CAP)) | capEvent;
  assign nxt_pFlag = running & pHit & ~(cmpLike & ctl1_ff.clearSourceSelect);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      capSync_ff <= 3'h0;
    end else if (clkEn) begin
      capSync_ff <= {capSync_ff[1:0], captureInPin};
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enPrev_ff <= 1'b0;
    end else if (clkEn) begin
      enPrev_ff <= ctl0_ff.moduleEnable;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= 10'h000;
    end else if (clkEn) begin
      if (enRise) begin
        count_ff <= 10'h000;
      end else if (running) begin
        count_ff <= clearHit ? 10'h000 : nxtCount[9:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      compareAFlag <= 1'b0;
      comparePFlag <= 1'b0;
    end else if (clkEn) begin
      compareAFlag <= nxt_aFlag;
      comparePFlag <= nxt_pFlag;
    end
  end

  // control registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl0_ff <= stm_ctl0_t'(`STM_CTL0_RST);
      ctl1_ff <= stm_ctl1_t'(`STM_CTL1_RST);
    end else if (clkEn && regWr) begin
      if (regAddr == `STM_ADDR_CTL0) begin
        ctl0_ff <= stm_ctl0_t'(regWrData);
      end else if (regAddr == `STM_ADDR_CTL1) begin
        ctl1_ff <= stm_ctl1_t'(regWrData);
      end
    end
  end

  // low write fills buffer, high write commits, high read refills it
  // capture wins over a same-cycle software commit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmpBuf_ff <= 8'h00;
      cmpA_ff   <= 10'h000;
    end else if (clkEn) begin
      if (regWr && regAddr == `STM_ADDR_CMPA_LO) begin
        cmpBuf_ff <= regWrData;
      end else if (regRd && regAddr == `STM_ADDR_CMPA_HI) begin
        cmpBuf_ff <= cmpA_ff[7:0];
      end
      if (capEvent) begin
        cmpA_ff <= count_ff;
      end else if (regWr && regAddr == `STM_ADDR_CMPA_HI) begin
        cmpA_ff <= {regWrData[1:0], cmpBuf_ff};
      end
    end
  end

  // read path, high byte read latches low byte
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 8'h00;
      cntBuf_ff <= 8'h00;
    end else if (clkEn) begin
      regRdData <= 8'h00;
      if (regRd) begin
        if (regAddr == `STM_ADDR_CTL0) begin
          regRdData <= ctl0_ff;
        end else if (regAddr == `STM_ADDR_CTL1) begin
          regRdData <= ctl1_ff;
        end else if (regAddr == `STM_ADDR_CNT_LO) begin
          regRdData <= cntBuf_ff;
        end else if (regAddr == `STM_ADDR_CNT_HI) begin
          regRdData <= {6'h00, count_ff[9:8]};
          cntBuf_ff <= count_ff[7:0];
        end else if (regAddr == `STM_ADDR_CMPA_LO) begin
          regRdData <= cmpBuf_ff;
        end else if (regAddr == `STM_ADDR_CMPA_HI) begin
          regRdData <= {6'h00, cmpA_ff[9:8]};
        end
      end
    end
  end

  // the compare low byte shares its buffer between write and read-back
  // pin level before polarity
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinLevel_ff <= 1'b0;
    end else if (clkEn) begin
      if (enRise) begin
        if (mode == STM_MODE_PWM && ctl1_ff.pinFunctionSelect == 2'h0) begin
          pinLevel_ff <= ~ctl1_ff.outputInitialLevel;
        end else if (mode != STM_MODE_CAP && mode != STM_MODE_TMR) begin
          pinLevel_ff <= ctl1_ff.outputInitialLevel;
        end
      end else if (mode == STM_MODE_CMP && running && aHit) begin
        // set, clear or toggle on A match
        case (ctl1_ff.pinFunctionSelect)
          2'h1:    pinLevel_ff <= 1'b0;
          2'h2:    pinLevel_ff <= 1'b1;
          2'h3:    pinLevel_ff <= ~pinLevel_ff;
          default: pinLevel_ff <= pinLevel_ff;
        endcase
      end else if (mode == STM_MODE_PWM && ctl0_ff.moduleEnable) begin
        // PWM functions, level follows active polarity
        case (ctl1_ff.pinFunctionSelect)
          2'h0: pinLevel_ff <= ~ctl1_ff.outputInitialLevel;
          2'h1: pinLevel_ff <= ctl1_ff.outputInitialLevel;
          2'h2: pinLevel_ff <= ({1'b0, count_ff} < pwmDuty) ?
                               ctl1_ff.outputInitialLevel : ~ctl1_ff.outputInitialLevel;
          default: begin
            if (running && aHit) begin
              pinLevel_ff <= ~ctl1_ff.outputInitialLevel;
            end
          end
        endcase
      end
    end
  end

  // polarity, timer mode keeps last pin state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timerOutPin <= 1'b0;
    end else if (clkEn && mode != STM_MODE_TMR) begin
      timerOutPin <= pinLevel_ff ^ ctl1_ff.outputInvert;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_enRiseClr;
    clkEn && enRise |=> count_ff == 10'h000;
  endproperty
  a_enRiseClr: assert property (p_enRiseClr) else $error("enable rise did not clear count");

  property p_offHold;
    clkEn && !ctl0_ff.moduleEnable |=> $stable(count_ff);
  endproperty
  a_offHold: assert property (p_offHold) else $error("count moved while disabled");

  property p_pauseHold;
    clkEn && ctl0_ff.pauseCtl && !enRise |=> $stable(count_ff);
  endproperty
  a_pauseHold: assert property (p_pauseHold) else $error("count moved while paused");

  property p_runStep;
    clkEn && running && !clearHit && !enRise |=> count_ff == $past(count_ff) + 10'h001;
  endproperty
  a_runStep: assert property (p_runStep) else $error("count did not advance");

  property p_periodClr;
    clkEn && running && !enRise && mode == STM_MODE_CMP && !ctl1_ff.clearSourceSelect
      && ctl0_ff.periodCompareValue != 3'h0 && count_ff[6:0] == 7'h7f
      && (count_ff[9:7] + 3'h1) == ctl0_ff.periodCompareValue
      |=> count_ff == 10'h000 && comparePFlag;
  endproperty
  a_periodClr: assert property (p_periodClr) else $error("period match missed");

  property p_pFlagMask;
    clkEn && cmpLike && ctl1_ff.clearSourceSelect |=> !comparePFlag;
  endproperty
  a_pFlagMask: assert property (p_pFlagMask) else $error("P flag with A clear source");

  property p_hiCommit;
    clkEn && regWr && regAddr == `STM_ADDR_CMPA_HI && !capEvent
      |=> cmpA_ff == {$past(regWrData[1:0]), $past(cmpBuf_ff)};
  endproperty
  a_hiCommit: assert property (p_hiCommit) else $error("high byte commit wrong");

  property p_rdLatch;
    clkEn && regRd && regAddr == `STM_ADDR_CNT_HI
      |=> cntBuf_ff == $past(count_ff[7:0]) && regRdData == {6'h00, $past(count_ff[9:8])};
  endproperty
  a_rdLatch: assert property (p_rdLatch) else $error("counter high read wrong");

  property p_enRisePin;
    clkEn && enRise && mode == STM_MODE_CMP ##1 clkEn
      |=> timerOutPin == ($past(ctl1_ff.outputInitialLevel, 2) ^ $past(ctl1_ff.outputInvert));
  endproperty
  a_enRisePin: assert property (p_enRisePin) else $error("pin not at initial level");

  property p_toggle;
    clkEn && !enRise && running && aHit && mode == STM_MODE_CMP
      && ctl1_ff.pinFunctionSelect == 2'h3 |=> pinLevel_ff != $past(pinLevel_ff);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle on A match missing");

  c_pwmPeriod: cover property (clkEn && mode == STM_MODE_PWM && running && clearHit);
  c_capture:   cover property (clkEn && capEvent);
  c_pulseEnd:  cover property (clkEn && mode == STM_MODE_PWM && running && aHit
                               && ctl1_ff.pinFunctionSelect == 2'h3);

endmodule

`default_nettype wire
